//--- hw/pwa_pin_action.sv
`timescale 1ns/1ps

module pwa_pin_action
    import pwa_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [CNT_W-1:0] i_counter,
    input wire logic i_count_en,
    input wire logic i_cycle_end,
    input wire logic i_pin_a_in,
    input wire logic i_pin_b_in,
    output logic o_pin_a,
    output logic o_pin_a_oe,
    output logic o_pin_b,
    output logic o_pin_b_oe
);
    // =====================================================================
    // State
    typedef struct packed {
        logic [NUM_PINS-1:0][FIELD_W-1:0] field;
        logic [NUM_PINS-1:0][CNT_W-1:0] ccr;
        logic run;
        logic legacy;
        logic [NUM_PINS-1:0] pin;
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] cap_prev;
        logic [NUM_PINS-1:0] cap_flag;
        logic [31:0] rdata;
    } pwa_state_type;

    localparam pwa_state_type STATE_RST = '{
        field: {NUM_PINS{FIELD_RST}},
        ccr: {NUM_PINS{CCR_RST}},
        run: 1'b0,
        legacy: 1'b0,
        pin: '0,
        oe: '1,
        cap_prev: '0,
        cap_flag: '0,
        rdata: 32'h00000000
    };

    pwa_state_type st;
    pwa_state_type next_st;

    logic [NUM_PINS-1:0] pin_in;
    logic [NUM_PINS-1:0] cap_mode;
    logic [NUM_PINS-1:0] next_level;
    logic [NUM_PINS-1:0] capture;

    assign pin_in = {i_pin_b_in, i_pin_a_in};

    // =====================================================================
    // Per-pin action logic
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            pwa_pin_unit i_pwa_pin_unit (
                .i_field(st.field[gi]),
                .i_legacy(st.legacy),
                .i_run(st.run),
                .i_cycle_end(i_cycle_end),
                .i_count_en(i_count_en),
                .i_counter(i_counter),
                .i_ccr(st.ccr[gi]),
                .i_cap_now(pin_in[gi]),
                .i_cap_prev(st.cap_prev[gi]),
                .i_level(st.pin[gi]),
                .o_capture_mode(cap_mode[gi]),
                .o_next_level(next_level[gi]),
                .o_capture(capture[gi])
            );
        end
    endgenerate

    // =====================================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.rdata = 32'h00000000;
        next_st.cap_prev = pin_in;
        next_st.pin = next_level;
        next_st.oe = ~cap_mode;
        if (i_wr) begin
            unique case (i_addr)
                ADDR_FIELD_A: next_st.field[0] = i_wdata[FIELD_W-1:0];
                ADDR_FIELD_B: next_st.field[1] = i_wdata[FIELD_W-1:0];
                ADDR_CCR_A: next_st.ccr[0] = i_wdata[CNT_W-1:0];
                ADDR_CCR_B: next_st.ccr[1] = i_wdata[CNT_W-1:0];
                ADDR_CTRL: begin
                    next_st.run = i_wdata[CTRL_RUN];
                    next_st.legacy = i_wdata[CTRL_LEGACY];
                end
                ADDR_STATUS: begin
                    next_st.cap_flag = st.cap_flag & ~i_wdata[ST_CAP_LO +: NUM_PINS];
                end
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        // Capture beats a software write to the same register and a flag clear
        for (int i = 0; i < NUM_PINS; i++) begin
            if (capture[i]) begin
                next_st.ccr[i] = i_counter;
                next_st.cap_flag[i] = 1'b1;
            end
        end
        if (i_rd) begin
            unique case (i_addr)
                ADDR_FIELD_A: next_st.rdata = {26'h0000000, st.field[0]};
                ADDR_FIELD_B: next_st.rdata = {26'h0000000, st.field[1]};
                ADDR_CCR_A: next_st.rdata = {16'h0000, st.ccr[0]};
                ADDR_CCR_B: next_st.rdata = {16'h0000, st.ccr[1]};
                ADDR_CTRL: next_st.rdata = {30'h00000000, st.legacy, st.run};
                ADDR_STATUS: next_st.rdata = {28'h0000000, st.cap_flag, st.pin};
                default: next_st.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st <= STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_pin_a = st.pin[0];
    assign o_pin_b = st.pin[1];
    assign o_pin_a_oe = st.oe[0];
    assign o_pin_b_oe = st.oe[1];
endmodule

//--- hw/pwa_pin_unit.sv
// Behaviour
// - Bit 4 of a pin's action field sets the level the pin drives before any timer event.
// - At each counter cycle end the pin is kept, driven low, driven high or inverted per bits 3:2.
// - On a compare match with its own register the pin is kept, low, high or inverted per bits 1:0.
// - In legacy mode bit 5 high turns the pin into a capture input, edge chosen by bits 1:0.
`timescale 1ns/1ps

package pwa_pkg;

    // =====================================================================
    // Widths
    localparam int CNT_W = 16;
    localparam int FIELD_W = 6;
    localparam int ADDR_W = 5;
    localparam int NUM_PINS = 2;

    // =====================================================================
    // Register map, byte addresses
    localparam logic [ADDR_W-1:0] ADDR_FIELD_A = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_FIELD_B = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_CCR_A = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_CCR_B = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h14;

    // =====================================================================
    // Action field layout
    localparam int FB_CAPTURE = 5;
    localparam int FB_INIT = 4;
    localparam int FB_CYC_HI = 3;
    localparam int FB_CYC_LO = 2;
    localparam int FB_CMP_HI = 1;
    localparam int FB_CMP_LO = 0;

    localparam logic [1:0] ACT_KEEP = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    // =====================================================================
    // Control and status bits
    localparam int CTRL_RUN = 0;
    localparam int CTRL_LEGACY = 1;
    localparam int ST_PIN_LO = 0;
    localparam int ST_CAP_LO = 2;

    // =====================================================================
    // Reset values
    localparam logic [FIELD_W-1:0] FIELD_RST = 6'h00;
    localparam logic [CNT_W-1:0] CCR_RST = 16'hFFFF;

    function automatic logic act_apply(input logic level, input logic [1:0] code);
        logic r;
        r = level;
        unique case (code)
            ACT_KEEP: r = level;
            ACT_LOW: r = 1'b0;
            ACT_HIGH: r = 1'b1;
            ACT_TOGGLE: r = ~level;
        endcase
        return r;
    endfunction

endpackage

module pwa_pin_unit
    import pwa_pkg::*;
(
    input wire logic [FIELD_W-1:0] i_field,
    input wire logic i_legacy,
    input wire logic i_run,
    input wire logic i_cycle_end,
    input wire logic i_count_en,
    input wire logic [CNT_W-1:0] i_counter,
    input wire logic [CNT_W-1:0] i_ccr,
    input wire logic i_cap_now,
    input wire logic i_cap_prev,
    input wire logic i_level,
    output logic o_capture_mode,
    output logic o_next_level,
    output logic o_capture
);
    logic lvl_cyc;
    logic match;
    logic rise;
    logic fall;

    always_comb begin
        o_capture_mode = i_legacy && i_field[FB_CAPTURE];
        match = i_run && i_count_en && (i_counter == i_ccr) && !o_capture_mode;
        rise = i_cap_now && !i_cap_prev;
        fall = !i_cap_now && i_cap_prev;
        // Cycle end first, then match, so both events in one cycle compose
        lvl_cyc = (i_run && i_cycle_end) ?
            act_apply(i_level, i_field[FB_CYC_HI:FB_CYC_LO]) : i_level;
        if (o_capture_mode) begin
            // Bits 4:2 unused while capturing, so the level stays put
            o_next_level = i_level;
        end else if (!i_run) begin
            o_next_level = i_field[FB_INIT];
        end else if (match) begin
            o_next_level = act_apply(lvl_cyc, i_field[FB_CMP_HI:FB_CMP_LO]);
        end else begin
            o_next_level = lvl_cyc;
        end
        o_capture = 1'b0;
        if (o_capture_mode && i_run) begin
            unique case (i_field[FB_CMP_HI:FB_CMP_LO])
                EDGE_RISE: o_capture = rise;
                EDGE_FALL: o_capture = fall;
                default: o_capture = rise || fall;
            endcase
        end
    end
endmodule

//--- tb/pwa_pin_action_props.sv
`timescale 1ns/1ps

module pwa_pin_action_props (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic i_count_en,
    input wire logic i_cycle_end,
    input wire logic o_pin_a,
    input wire logic o_pin_a_oe,
    input wire logic o_pin_b,
    input wire logic o_pin_b_oe
);
    // ========
    // Pins move only on a write or a timer event
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence quiet_s;
        (!i_wr && !i_cycle_end && !i_count_en)[*2];
    endsequence
    reset_level_a: assert property ($fell(i_rst) |-> !o_pin_a && !o_pin_b && o_pin_a_oe && o_pin_b_oe)
        else $error("pin not low and driven after reset");
    // A capturing pin is an input, so its output level must not move
    cap_a_hold_a: assert property (!o_pin_a_oe |-> $stable(o_pin_a))
        else $error("pin a level moved in capture mode");
    cap_b_hold_a: assert property (!o_pin_b_oe |-> $stable(o_pin_b))
        else $error("pin b level moved in capture mode");
    pin_a_hold_a: assert property (quiet_s ##0 o_pin_a_oe |=> $stable(o_pin_a))
        else $error("pin a moved without cause");
    pin_b_hold_a: assert property (quiet_s ##0 o_pin_b_oe |=> $stable(o_pin_b))
        else $error("pin b moved without cause");
    // Enable depends on fields and mode only, so it needs a write to move
    oe_a_hold_a: assert property (!i_wr [*2] |=> $stable(o_pin_a_oe))
        else $error("pin a enable moved without write");
    oe_b_hold_a: assert property (!i_wr [*2] |=> $stable(o_pin_b_oe))
        else $error("pin b enable moved without write");
endmodule

bind pwa_pin_action pwa_pin_action_props i_props (.i_clk_sys, .i_rst, .i_wr, .i_count_en,
    .i_cycle_end, .o_pin_a, .o_pin_a_oe, .o_pin_b, .o_pin_b_oe);

//--- tb/pwa_cap_src.sv
`timescale 1ns/1ps

module pwa_cap_src (
    input wire logic i_clk_sys,
    input wire logic i_lvl,
    output logic o_pin
);
    // Registered so edges never land on the sampling edge
    always_ff @(posedge i_clk_sys) begin
        o_pin <= i_lvl;
    end
endmodule

//--- tb/pwa_pin_action_test.sv
`timescale 1ns/1ps

module pwa_pin_action_test;
    import pwa_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, ce = 0, cen = 0, lvl = 0;
    logic pa_in, pa, pa_oe, pb, pb_oe;
    logic [4:0] adr = 0;
    logic [31:0] wd = 0, rdv;
    logic [15:0] cnt = 0;
    int err_total = 0, num_checks = 0;

    pwa_pin_action i_pwa_pin_action (.i_clk_sys(clk), .i_rst(rst), .i_addr(adr), .i_wdata(wd),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdv), .i_counter(cnt), .i_count_en(cen),
        .i_cycle_end(ce), .i_pin_a_in(pa_in), .i_pin_b_in(pa_in), .o_pin_a(pa),
        .o_pin_a_oe(pa_oe), .o_pin_b(pb), .o_pin_b_oe(pb_oe));
    pwa_cap_src i_pwa_cap_src (.i_clk_sys(clk), .i_lvl(lvl), .o_pin(pa_in));

    // ========
    // Bus and check tasks
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h saw %h", n, e, s);
        end
    endtask
    task automatic wrt(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        @(posedge clk);
        adr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk("rdata", rdv, e);
    endtask
    task automatic pulse(input logic m);
        @(posedge clk);
        cen <= m;
        ce <= !m;
        @(posedge clk);
        cen <= 1'h0;
        ce <= 1'h0;
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ========
    // Tests
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        rdc(ADDR_CCR_A, 32'hFFFF);
        rdc(5'h18, 32'h0);
        chk("pin a", {pa_oe, pa}, 32'h2);
        $display("reset test done");
        wrt(ADDR_CCR_B, 32'h5);
        cnt <= 16'h0005;
        for (int c = 0; c < 4; c++) begin
            wrt(ADDR_CTRL, 32'h0);
            wrt(ADDR_FIELD_A, 32'h10 | (c << 2));
            wrt(ADDR_FIELD_B, 32'h10 | c);
            repeat (2) @(posedge clk);
            #1 chk("init a", {31'h0, pa}, 32'h1);
            chk("init b", {31'h0, pb}, 32'h1);
            wrt(ADDR_CTRL, 32'h1);
            pulse(1'h0);
            chk("cycle end a", {31'h0, pa}, {31'h0, !c[0]});
            pulse(1'h1);
            chk("match b", {31'h0, pb}, {31'h0, !c[0]});
        end
        $display("action test done");
        wrt(ADDR_CTRL, 32'h3);
        wrt(ADDR_FIELD_B, 32'h22);
        for (int e = 0; e < 4; e++) begin
            wrt(ADDR_FIELD_A, 32'h20 | e);
            wrt(ADDR_CCR_A, 32'h0);
            cnt <= 16'h0100;
            lvl <= 1'h1;
            repeat (4) @(posedge clk);
            rdc(ADDR_CCR_A, (e == 1) ? 32'h0 : 32'h100);
            cnt <= 16'h0200;
            lvl <= 1'h0;
            repeat (4) @(posedge clk);
            rdc(ADDR_CCR_A, (e == 0) ? 32'h100 : 32'h200);
            chk("oe a", {31'h0, pa_oe}, 32'h0);
        end
        rdc(ADDR_CCR_B, 32'h200);
        chk("oe b", {31'h0, pb_oe}, 32'h0);
        rdc(ADDR_FIELD_A, 32'h23);
        rdc(ADDR_STATUS, 32'hC);
        wrt(ADDR_STATUS, 32'hC);
        rdc(ADDR_STATUS, 32'h0);
        $display("capture test done");
        conclude();
    end
    initial begin
        #20000;
        err_total++;
        conclude();
    end
endmodule
